// >>> hw/sbsc_map.svh
`ifndef SBSC_MAP_SVH
`define SBSC_MAP_SVH

// Widths of the 256K x 36 variant
`define SBSC_ADDR_W    18
`define SBSC_HI_W      16
`define SBSC_LO_W      2
`define SBSC_DATA_W    36
`define SBSC_LANE_W    9
`define SBSC_LANES     4
`define SBSC_DEPTH     262144

// Reset values
`define SBSC_LO_RST    2'h0
`define SBSC_HI_RST    16'h0000
`define SBSC_ADDR_RST  18'h00000
`define SBSC_DATA_RST  36'h000000000
`define SBSC_GAP_RST   2'h0

// Burst counter step and lane codes
`define SBSC_STEP      2'h1
`define SBSC_LANES_OFF 4'hF
`define SBSC_LANES_ALL 4'h0
`define SBSC_MASK_ALL  4'hF
`define SBSC_MASK_NONE 4'h0

// Read latency in clock edges, command edge to sampling edge
`define SBSC_GAP_W     2
`define SBSC_LAT_FLOW  2'h1
`define SBSC_LAT_PIPE  2'h2
`define SBSC_GAP_STEP  2'h1

`endif

// >>> hw/sbsc_pkg.sv
`include "sbsc_map.svh"

package sbsc_pkg;

  // Kind of cycle taken at the last clock edge
  typedef enum logic [1:0] {
    SBSC_DESEL = 2'b00,
    SBSC_READ  = 2'b01,
    SBSC_WRITE = 2'b10
  } sbsc_cycle_e;

  typedef logic [`SBSC_ADDR_W-1:0] sbsc_addr_t;
  typedef logic [`SBSC_DATA_W-1:0] sbsc_data_t;
  typedef logic [`SBSC_LANES-1:0]  sbsc_lanes_t;

endpackage

// >>> hw/sbsc_if.sv
`timescale 1ns/1ps
`include "sbsc_map.svh"

interface sbsc_if;
  // Synchronous controls from the host
  logic                chip_select_n;
  logic                proc_addr_strobe_n;
  logic                ctrl_addr_strobe_n;
  logic                burst_step_n;
  logic                global_write_n;
  logic                byte_write_n;
  logic                lane_a_enable_n;
  logic                lane_b_enable_n;
  logic                lane_c_enable_n;
  logic                lane_d_enable_n;
  sbsc_pkg::sbsc_addr_t addr;
  // Asynchronous output enable and mode straps
  logic                out_enable_n;
  logic                burst_order_sel;
  logic                flow_through_sel;
  // Data bus halves and the resolved level
  sbsc_pkg::sbsc_data_t host_dq_out;
  logic                host_dq_oe;
  sbsc_pkg::sbsc_data_t dev_dq_out;
  logic                dev_dq_oe;
  sbsc_pkg::sbsc_data_t dq;

  // Bus level: whichever end drives; floating bus reads as zero
  assign dq = dev_dq_oe ? dev_dq_out :
              (host_dq_oe ? host_dq_out : `SBSC_DATA_RST);

  modport device (
    input  chip_select_n, proc_addr_strobe_n, ctrl_addr_strobe_n,
    input  burst_step_n, global_write_n, byte_write_n,
    input  lane_a_enable_n, lane_b_enable_n, lane_c_enable_n,
    input  lane_d_enable_n, addr, out_enable_n, burst_order_sel,
    input  flow_through_sel, dq,
    output dev_dq_out, dev_dq_oe
  );

  modport host (
    output chip_select_n, proc_addr_strobe_n, ctrl_addr_strobe_n,
    output burst_step_n, global_write_n, byte_write_n,
    output lane_a_enable_n, lane_b_enable_n, lane_c_enable_n,
    output lane_d_enable_n, addr, out_enable_n, burst_order_sel,
    output flow_through_sel, host_dq_out, host_dq_oe,
    input  dq
  );
endinterface

// >>> hw/sbsc_device.sv
// How it works
// - Interleaved order: start XOR 00,01,10,11.
// - Counter wraps to start on fifth clock.
// - Byte write low writes lanes enabled low.
// - Store qualifier true when any lane written.
// - Reads drive all lanes regardless of enables.
// - Data pins stay released during writes.
// - Lanes c and d exist in wide variant.
// - Select high, controller strobe low: deselect.
// - Select low, processor strobe low: read begin.
// - Controller strobe begins write or read burst.
// - Strobes idle, advance low: next address.
// - Strobes idle, advance high: same address.
// - Output enable gates drivers without the clock.
// - Host may run non-burst with strobes tied.
// - Host may burst with controller strobe only.
// - Dummy reads hold the counter; advance stays high.
// - Host uses dummy reads before writes.
// - Order select low linear, high interleaved.
// - Linear order adds one modulo four.
// - Flow-through low bypasses the output register.
`timescale 1ns/1ps
`include "sbsc_map.svh"

module sbsc_device (
  // Clock, reset and freeze
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  input  wire logic                 clk_en,
  // Memory bus toward the host
  sbsc_if.device                    link,
  // Observation of the last cycle taken
  output sbsc_pkg::sbsc_cycle_e     last_cycle,
  output sbsc_pkg::sbsc_addr_t      last_addr
);

  // Low address bits for a burst position
  function automatic logic [`SBSC_LO_W-1:0] burst_lo(
    input logic [`SBSC_LO_W-1:0] start,
    input logic [`SBSC_LO_W-1:0] cnt,
    input logic                  order
  );
    logic [`SBSC_LO_W-1:0] sum;
    sum = start + cnt;
    burst_lo = order ? (start ^ cnt) : sum;
  endfunction

  // Lanes to write from the write controls
  function automatic logic [`SBSC_LANES-1:0] lane_mask(
    input logic                   gw_n,
    input logic                   bw_n,
    input logic [`SBSC_LANES-1:0] lanes_n
  );
    if (!gw_n) begin
      lane_mask = `SBSC_MASK_ALL;
    end else if (!bw_n) begin
      lane_mask = ~lanes_n;
    end else begin
      lane_mask = `SBSC_MASK_NONE;
    end
  endfunction

  // Storage array
  sbsc_pkg::sbsc_data_t       mem [0:`SBSC_DEPTH-1];

  // Burst address state
  logic [`SBSC_HI_W-1:0]      hi_reg;
  logic [`SBSC_HI_W-1:0]      hi_next;
  logic [`SBSC_LO_W-1:0]      start_reg;
  logic [`SBSC_LO_W-1:0]      start_next;
  logic [`SBSC_LO_W-1:0]      cnt_reg;
  logic [`SBSC_LO_W-1:0]      cnt_next;

  // Cycle state and read path
  sbsc_pkg::sbsc_cycle_e      cyc_reg;
  sbsc_pkg::sbsc_cycle_e      cyc_next;
  logic                       pipe_rd_reg;
  logic                       pipe_rd_next;
  sbsc_pkg::sbsc_data_t       rd_data_reg;
  sbsc_pkg::sbsc_data_t       pipe_data_reg;
  sbsc_pkg::sbsc_addr_t       last_addr_reg;

  // Decoded controls
  logic [`SBSC_LANES-1:0]     lanes_n_w;
  logic [`SBSC_LANES-1:0]     mask_w;
  logic                       desel_w;
  logic                       beg_proc_w;
  logic                       beg_ctrl_w;
  logic                       begin_w;
  logic                       cont_w;
  logic                       adv_w;
  logic                       store_w;
  logic                       flow_w;
  logic                       drive_w;
  sbsc_pkg::sbsc_addr_t       op_addr_w;

  // All four lanes are present in this wide variant
  assign lanes_n_w = {link.lane_d_enable_n, link.lane_c_enable_n,
                      link.lane_b_enable_n, link.lane_a_enable_n};

  // Synchronous command decode
  assign desel_w    = link.chip_select_n
                    & ~link.ctrl_addr_strobe_n;
  assign beg_proc_w = ~link.chip_select_n
                    & ~link.proc_addr_strobe_n;
  assign beg_ctrl_w = ~link.chip_select_n
                    & link.proc_addr_strobe_n
                    & ~link.ctrl_addr_strobe_n;
  assign begin_w    = beg_proc_w | beg_ctrl_w;
  assign cont_w     = ~desel_w & ~begin_w;
  assign adv_w      = cont_w & ~link.burst_step_n;

  // Write lanes; a processor-strobe begin is always a read
  assign mask_w  = beg_proc_w ? `SBSC_MASK_NONE
                 : lane_mask(link.global_write_n, link.byte_write_n,
                             lanes_n_w);
  assign store_w = |mask_w;

  // Burst counter: preset on begin, step on advance, else hold
  assign cnt_next   = begin_w ? `SBSC_LO_RST
                    : (adv_w ? cnt_reg + `SBSC_STEP : cnt_reg);
  assign start_next = begin_w ? link.addr[`SBSC_LO_W-1:0]
                    : start_reg;
  assign hi_next    = begin_w ? link.addr[`SBSC_ADDR_W-1:`SBSC_LO_W]
                    : hi_reg;
  assign op_addr_w  = {hi_next,
                       burst_lo(start_next, cnt_next,
                                link.burst_order_sel)};

  // Kind of cycle taken at this edge
  assign cyc_next = desel_w ? sbsc_pkg::SBSC_DESEL
                  : (store_w ? sbsc_pkg::SBSC_WRITE
                             : sbsc_pkg::SBSC_READ);

  // Pipelined drive survives a deselect but not a write
  assign pipe_rd_next = (cyc_reg == sbsc_pkg::SBSC_READ)
                      & (cyc_next != sbsc_pkg::SBSC_WRITE);

  // Flow-through low selects the bypass path
  assign flow_w = ~link.flow_through_sel;

  // Driver activity from the synchronous state
  always_comb begin
    case (cyc_reg)
      sbsc_pkg::SBSC_READ:  drive_w = flow_w ? 1'b1 : pipe_rd_reg;
      sbsc_pkg::SBSC_WRITE: drive_w = flow_w ? 1'b0 : pipe_rd_reg;
      sbsc_pkg::SBSC_DESEL: drive_w = flow_w ? 1'b0 : pipe_rd_reg;
      default:              drive_w = 1'b0;
    endcase
  end

  // Output enable acts with no clock involved
  assign link.dev_dq_oe  = drive_w & ~link.out_enable_n;
  assign link.dev_dq_out = flow_w ? rd_data_reg
                                  : pipe_data_reg;

  assign last_cycle = cyc_reg;
  assign last_addr  = last_addr_reg;

  // Address and cycle registers, rising edge only
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hi_reg        <= `SBSC_HI_RST;
      start_reg     <= `SBSC_LO_RST;
      cnt_reg       <= `SBSC_LO_RST;
      cyc_reg       <= sbsc_pkg::SBSC_DESEL;
      pipe_rd_reg   <= 1'b0;
      last_addr_reg <= `SBSC_ADDR_RST;
    end else if (clk_en) begin
      hi_reg        <= hi_next;
      start_reg     <= start_next;
      cnt_reg       <= cnt_next;
      cyc_reg       <= cyc_next;
      pipe_rd_reg   <= pipe_rd_next;
      last_addr_reg <= op_addr_w;
    end
  end

  // Read data and output register stages
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_reg   <= `SBSC_DATA_RST;
      pipe_data_reg <= `SBSC_DATA_RST;
    end else if (clk_en) begin
      if (cyc_next == sbsc_pkg::SBSC_READ) begin
        rd_data_reg <= mem[op_addr_w];
      end
      pipe_data_reg <= rd_data_reg;
    end
  end

  // Lane writes into the array, data taken at the command edge
  always_ff @(posedge ref_clk) begin
    if (clk_en && !desel_w) begin
      for (int i = 0; i < `SBSC_LANES; i++) begin
        if (mask_w[i]) begin
          mem[op_addr_w][i*`SBSC_LANE_W +: `SBSC_LANE_W]
            <= link.dq[i*`SBSC_LANE_W +: `SBSC_LANE_W];
        end
      end
    end
  end

endmodule

// >>> hw/sbsc_host.sv
`timescale 1ns/1ps
`include "sbsc_map.svh"

module sbsc_host (
  // Clock, reset and freeze
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  input  wire logic                 clk_en,
  // Mode straps
  input  wire logic                 order_sel_in,
  input  wire logic                 flow_sel_in,
  // Command port
  input  wire logic                 cmd_valid,
  output logic                      cmd_ready,
  input  wire logic                 cmd_write,
  input  wire logic                 cmd_next,
  input  sbsc_pkg::sbsc_addr_t      cmd_addr,
  input  sbsc_pkg::sbsc_data_t      cmd_wdata,
  input  sbsc_pkg::sbsc_lanes_t     cmd_lanes_n,
  // Read answers
  output logic                      rsp_valid,
  output sbsc_pkg::sbsc_data_t      rsp_data,
  // Memory bus toward the device
  sbsc_if.host                      link
);

  // Pin registers
  logic                   cs_n_reg;
  logic                   proc_n_reg;
  logic                   ctrl_n_reg;
  logic                   step_n_reg;
  logic                   gw_n_reg;
  logic                   bw_n_reg;
  sbsc_pkg::sbsc_lanes_t  lanes_n_reg;
  sbsc_pkg::sbsc_addr_t   addr_reg;
  sbsc_pkg::sbsc_data_t   dq_out_reg;
  logic                   dq_oe_reg;
  logic                   oe_n_reg;

  // Turnaround and answer tracking
  logic [`SBSC_GAP_W-1:0] gap_reg;
  logic [`SBSC_GAP_W-1:0] lat_w;
  logic                   rd_now_reg;
  logic                   rd_prev_reg;
  logic                   rsp_valid_reg;
  sbsc_pkg::sbsc_data_t   rsp_data_reg;

  // Handshake decode
  logic                   gap_busy_w;
  logic                   take_w;
  logic                   dummy_w;
  logic                   take_rd_w;
  logic                   take_wr_w;
  logic                   use_global_w;

  assign lat_w        = flow_sel_in ? `SBSC_LAT_PIPE : `SBSC_LAT_FLOW;
  assign gap_busy_w   = gap_reg != `SBSC_GAP_RST;
  assign cmd_ready    = clk_en & ~(cmd_write & gap_busy_w);
  assign take_w       = cmd_valid & cmd_ready;
  assign dummy_w      = cmd_valid & cmd_write & gap_busy_w;
  assign take_rd_w    = take_w & ~cmd_write;
  assign take_wr_w    = take_w & cmd_write;
  assign use_global_w = cmd_lanes_n == `SBSC_LANES_ALL;

  // Pins driven from registers; the mode straps come straight from the inputs
  assign link.chip_select_n      = cs_n_reg;
  assign link.proc_addr_strobe_n = proc_n_reg;
  assign link.ctrl_addr_strobe_n = ctrl_n_reg;
  assign link.burst_step_n       = step_n_reg;
  assign link.global_write_n     = gw_n_reg;
  assign link.byte_write_n       = bw_n_reg;
  assign link.lane_a_enable_n    = lanes_n_reg[0];
  assign link.lane_b_enable_n    = lanes_n_reg[1];
  assign link.lane_c_enable_n    = lanes_n_reg[2];
  assign link.lane_d_enable_n    = lanes_n_reg[3];
  assign link.addr               = addr_reg;
  assign link.host_dq_out        = dq_out_reg;
  assign link.host_dq_oe         = dq_oe_reg;
  assign link.out_enable_n       = oe_n_reg;
  assign link.burst_order_sel    = order_sel_in;
  assign link.flow_through_sel   = flow_sel_in;
  assign rsp_valid               = rsp_valid_reg;
  assign rsp_data                = rsp_data_reg;

  // Command pins: controller strobe begins, advance continues
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_n_reg    <= 1'b1;
      proc_n_reg  <= 1'b1;
      ctrl_n_reg  <= 1'b0;
      step_n_reg  <= 1'b1;
      gw_n_reg    <= 1'b1;
      bw_n_reg    <= 1'b1;
      lanes_n_reg <= `SBSC_LANES_OFF;
      addr_reg    <= `SBSC_ADDR_RST;
      dq_out_reg  <= `SBSC_DATA_RST;
      dq_oe_reg   <= 1'b0;
    end else if (clk_en) begin
      cs_n_reg    <= ~(take_w | dummy_w);
      proc_n_reg  <= 1'b1;
      ctrl_n_reg  <= ~(take_w & ~cmd_next) & ~(~take_w & ~dummy_w);
      step_n_reg  <= ~(take_w & cmd_next);
      gw_n_reg    <= ~(take_wr_w & use_global_w);
      bw_n_reg    <= ~(take_wr_w & ~use_global_w);
      lanes_n_reg <= take_wr_w ? cmd_lanes_n : `SBSC_LANES_OFF;
      addr_reg    <= take_w ? cmd_addr : addr_reg;
      dq_out_reg  <= take_wr_w ? cmd_wdata : dq_out_reg;
      dq_oe_reg   <= take_wr_w;
    end
  end

  // Read tracking, output enable and answer capture
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_reg       <= `SBSC_GAP_RST;
      rd_now_reg    <= 1'b0;
      rd_prev_reg   <= 1'b0;
      oe_n_reg      <= 1'b1;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg  <= `SBSC_DATA_RST;
    end else if (clk_en) begin
      gap_reg       <= take_rd_w ? lat_w
                     : (gap_busy_w ? gap_reg - `SBSC_GAP_STEP
                                   : gap_reg);
      rd_now_reg    <= take_rd_w;
      rd_prev_reg   <= rd_now_reg;
      oe_n_reg      <= ~(flow_sel_in ? rd_prev_reg : rd_now_reg);
      rsp_valid_reg <= ~oe_n_reg;
      rsp_data_reg  <= ~oe_n_reg ? link.dq : rsp_data_reg;
    end
  end

endmodule

// >>> tb/sbsc_link_monitor.sv
`timescale 1ns/1ps

module sbsc_link_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Host controls
  input wire logic chip_select_n,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic global_write_n,
  input wire logic byte_write_n,
  input wire logic lane_a_enable_n,
  input wire logic lane_b_enable_n,
  input wire logic lane_c_enable_n,
  input wire logic lane_d_enable_n,
  input wire logic out_enable_n,
  input wire logic flow_through_sel,
  // Bus drivers
  input wire logic host_dq_oe,
  input wire logic dev_dq_oe
);
  // Command decode of the sampled pins
  wire lanes_on   = !lane_a_enable_n || !lane_b_enable_n ||
                    !lane_c_enable_n || !lane_d_enable_n;
  wire store      = !global_write_n || (!byte_write_n && lanes_on);
  wire desel      = chip_select_n && !ctrl_addr_strobe_n;
  wire proc_begin = !chip_select_n && !proc_addr_strobe_n;
  wire wr         = store && !desel && !proc_begin;
  wire rd         = !desel && !wr;

  default clocking @(posedge ref_clk); endclocking
  // Frozen edges take no command, so no check runs across them
  default disable iff (!reset_n || !clk_en);

  write_release_a: assert property (wr |=> !dev_dq_oe)
    else $error("device drives after a write");
  oe_gate_a: assert property (out_enable_n |-> !dev_dq_oe)
    else $error("device drives with output enable high");
  desel_release_a: assert property (
    desel && !flow_through_sel |=> !dev_dq_oe)
    else $error("device drives after a deselect");
  flow_read_a: assert property (
    rd && !flow_through_sel |=> out_enable_n || dev_dq_oe)
    else $error("flow read not driven");
  pipe_read_a: assert property (
    rd && flow_through_sel |-> ##2 (out_enable_n || dev_dq_oe))
    else $error("pipelined read not driven");
  bus_single_a: assert property (!(host_dq_oe && dev_dq_oe))
    else $error("both ends drive the bus");
  write_data_a: assert property (wr |-> host_dq_oe)
    else $error("write without host data");
  oe_quiet_a: assert property (!out_enable_n |-> !host_dq_oe)
    else $error("output enabled while host drives");

  // Main traffic kinds
  flow_read_c: cover property (rd && !flow_through_sel ##1 dev_dq_oe);
  pipe_read_c: cover property (rd && flow_through_sel ##2 dev_dq_oe);
  turn_c:      cover property (wr ##1 rd);
  desel_c:     cover property (desel);
endmodule

// >>> tb/sync_burst_sram_control_tb_top.sv
`timescale 1ns/1ps

module sync_burst_sram_control_tb_top;
  // Stimulus and observed outputs
  logic                  ref_clk      = 1'b0;
  logic                  reset_n      = 1'b0;
  logic                  clk_en       = 1'b1;
  logic                  order_sel_in = 1'b0;
  logic                  flow_sel_in  = 1'b0;
  logic                  cmd_valid    = 1'b0;
  logic                  cmd_write    = 1'b0;
  logic                  cmd_next     = 1'b0;
  sbsc_pkg::sbsc_addr_t  cmd_addr     = 18'h00000;
  sbsc_pkg::sbsc_data_t  cmd_wdata    = 36'h000000000;
  sbsc_pkg::sbsc_lanes_t cmd_lanes_n  = 4'hF;
  logic                  cmd_ready;
  logic                  rsp_valid;
  sbsc_pkg::sbsc_data_t  rsp_data;
  sbsc_pkg::sbsc_cycle_e last_cycle;
  sbsc_pkg::sbsc_addr_t  last_addr;
  // Reference model state
  int                    n_mismatch = 0;
  int                    n_compared = 0;
  int                    seed       = 96;
  logic [35:0]           mem [logic [17:0]];
  logic [35:0]           exp_q [$];
  logic [15:0]           hi;
  logic [1:0]            st;
  logic [1:0]            n;
  logic                  tk_v = 1'b0;
  logic                  tk_w;
  logic [17:0]           tk_a;
  logic                  s1_v = 1'b0;
  logic                  s1_w;
  logic [17:0]           s1_a;
  logic                  en_seen = 1'b0;
  logic                  d0_v = 1'b0;
  logic [17:0]           d0_a;
  logic                  d1_v = 1'b0;
  logic [17:0]           d1_a;

  sbsc_if link ();

  sbsc_device sbsc_device_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .link(link),
    .last_cycle(last_cycle), .last_addr(last_addr));

  sbsc_host sbsc_host_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
    .order_sel_in(order_sel_in), .flow_sel_in(flow_sel_in),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_next(cmd_next), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_lanes_n(cmd_lanes_n), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .link(link));

  sbsc_link_monitor sbsc_link_monitor_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
    .chip_select_n(link.chip_select_n),
    .proc_addr_strobe_n(link.proc_addr_strobe_n),
    .ctrl_addr_strobe_n(link.ctrl_addr_strobe_n),
    .global_write_n(link.global_write_n),
    .byte_write_n(link.byte_write_n),
    .lane_a_enable_n(link.lane_a_enable_n),
    .lane_b_enable_n(link.lane_b_enable_n),
    .lane_c_enable_n(link.lane_c_enable_n),
    .lane_d_enable_n(link.lane_d_enable_n),
    .out_enable_n(link.out_enable_n),
    .flow_through_sel(link.flow_through_sel),
    .host_dq_oe(link.host_dq_oe), .dev_dq_oe(link.dev_dq_oe));

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  // Verdict and end of run
  task conclude;
    if (n_mismatch == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One command, held until taken; model follows the device counter
  task automatic issue(input logic w, input logic nx,
                       input logic [17:0] a, input logic [3:0] ln);
    logic        r;
    logic [35:0] d;
    logic [35:0] m;
    d = {4'($random(seed)), 32'($random(seed))};
    cmd_valid   <= 1'b1;
    cmd_write   <= w;
    cmd_next    <= nx;
    cmd_addr    <= a;
    cmd_wdata   <= d;
    cmd_lanes_n <= ln;
    r = 1'b0;
    for (int i = 0; i < 20 && !r; i++) begin
      @(negedge ref_clk);
      r = (cmd_ready === 1'b1);
      @(posedge ref_clk);
    end
    if (!r) begin
      n_mismatch++;
      $display("MISMATCH %0t command never taken", $time);
    end
    if (!nx) begin
      hi = a[17:2];
      st = a[1:0];
      n  = 2'h0;
    end else
      n = n + 2'h1;
    tk_a = {hi, order_sel_in ? (st ^ n) : (st + n)};
    tk_v = 1'b1;
    tk_w = w;
    if (w) begin
      m = mem[tk_a];
      for (int i = 0; i < 4; i++)
        if (!ln[i] || ln == 4'h0)
          m[9*i +: 9] = d[9*i +: 9];
      mem[tk_a] = m;
    end else
      exp_q.push_back(mem[tk_a]);
  endtask

  // Idle the port, then expect a deselect
  task automatic idle(input int c);
    cmd_valid <= 1'b0;
    repeat (c) @(posedge ref_clk);
    @(negedge ref_clk);
    n_compared++;
    if (last_cycle !== sbsc_pkg::SBSC_DESEL) begin
      n_mismatch++;
      $display("MISMATCH %0t idle cycle not deselect", $time);
    end
    @(posedge ref_clk);
  endtask

  // Hold clock enable low; no state may move meanwhile
  task automatic freeze(input int c);
    sbsc_pkg::sbsc_cycle_e k;
    sbsc_pkg::sbsc_addr_t  a;
    cmd_valid <= 1'b0;
    clk_en    <= 1'b0;
    @(negedge ref_clk);
    k = last_cycle;
    a = last_addr;
    repeat (c) @(posedge ref_clk);
    clk_en <= 1'b1;
    @(negedge ref_clk);
    n_compared++;
    if (last_cycle !== k || last_addr !== a) begin
      n_mismatch++;
      $display("MISMATCH %0t state moved while frozen", $time);
    end
    @(posedge ref_clk);
  endtask

  // Clock enable as the design saw it at each edge
  always @(posedge ref_clk) begin
    en_seen = clk_en;
  end

  // Address and cycle kind one enabled edge after each take
  always @(negedge ref_clk) begin
    if (en_seen) begin
      if (s1_v) begin
        n_compared++;
        if (last_addr !== s1_a || last_cycle !== (s1_w ?
            sbsc_pkg::SBSC_WRITE : sbsc_pkg::SBSC_READ)) begin
          n_mismatch++;
          $display("MISMATCH %0t address or cycle kind", $time);
        end
      end
      if (d1_v) begin
        n_compared++;
        if (last_addr !== d1_a ||
            last_cycle !== sbsc_pkg::SBSC_READ) begin
          n_mismatch++;
          $display("MISMATCH %0t suspend cycle moved", $time);
        end
      end
      s1_v = tk_v;
      s1_a = tk_a;
      s1_w = tk_w;
      tk_v = 1'b0;
      // A held write makes the host send a suspend read next edge
      d1_v = d0_v;
      d1_a = d0_a;
      d0_v = cmd_valid && cmd_write && cmd_ready !== 1'b1;
      d0_a = tk_a;
    end
  end

  // Read answers against the memory model, in order
  always @(negedge ref_clk) begin
    if (en_seen && rsp_valid === 1'b1) begin
      n_compared++;
      if (exp_q.size() == 0 || rsp_data !== exp_q[0]) begin
        n_mismatch++;
        $display("MISMATCH %0t read data", $time);
      end
      if (exp_q.size() > 0)
        void'(exp_q.pop_front());
    end
  end

  // Modes, global and byte writes, wrapping bursts, turnarounds
  initial begin
    logic [17:0] base;
    logic [3:0]  ln;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    for (int m = 0; m < 4; m++) begin
      flow_sel_in  <= m[0];
      order_sel_in <= m[1];
      idle(4);
      base = {16'($random(seed)), 2'h0};
      for (int i = 0; i < 4; i++)
        issue(1'b1, 1'b0, base | 18'(i), 4'h0);
      for (int i = 0; i < 3; i++) begin
        ln = 4'($random(seed));
        if (ln == 4'hF)
          ln = 4'h7;
        issue(1'b1, 1'b0, base | 18'($random(seed) & 3), ln);
      end
      freeze(3);
      issue(1'b0, 1'b0, base | 18'(m), 4'hF);
      for (int i = 0; i < 5; i++)
        issue(1'b0, 1'b1, base, 4'hF);
      issue(1'b1, 1'b0, base | 18'(3 - m), 4'h0);
      for (int i = 0; i < 3; i++)
        issue(1'b1, 1'b1, base, 4'h0);
      issue(1'b0, 1'b0, base | 18'h00001, 4'hF);
      for (int i = 0; i < 3; i++)
        issue(1'b0, 1'b1, base, 4'hF);
      idle(6);
    end
    n_compared++;
    if (exp_q.size() != 0) begin
      n_mismatch++;
      $display("MISMATCH %0t missing read answers", $time);
    end
    conclude;
  end

  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_mismatch++;
    $display("MISMATCH %0t watchdog expired", $time);
    conclude;
  end
endmodule
